// ---- tb/pps_pd_model.sv ----
// powered device model on the far side of the port sequencer
// assumes the sequencer controls are registered on ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module pps_pd_model (
  // clock
  input wire logic ref_clk_i,
  // sequencer controls
  input wire logic [1:0] det_force_i,
  input wire logic class_probe_i,
  // scenario settings
  input wire logic [15:0] sig_mv_i,
  input wire logic [2:0] cls_i,
  input wire logic pm_over_i,
  input wire logic over_i,
  // front end results
  output var pps_pkg::pps_meas_type meas_o
);
  import pps_pkg::*;
  logic [15:0] junk = 16'h5a5a;
  logic [15:0] volt;
  // undriven port reads a value that flips every cycle
  always @(posedge ref_clk_i) begin
    junk <= ~junk;
  end
  // offset under first current, offset plus slope under second
  assign volt = (det_force_i == DET_I1) ? 16'h03e8 :
    (det_force_i == DET_I2) ? 16'h03e8 + sig_mv_i : junk;
  assign meas_o = {volt, 1'b0, class_probe_i ? cls_i : ~cls_i,
    pm_over_i, over_i, 1'b0, 1'b0};
endmodule : pps_pd_model
`default_nettype wire

// ---- tb/pps_seq_tb_top.sv ----
// testbench of the port sequencer: apb tasks and port scenarios
// assumes pps_seq with a short tick and the powered device model
`timescale 1ns/1ps
`default_nettype none
`define CHK(N, E, G) begin compares++; if ((G) !== (E)) begin \
  failures++; $display("MISMATCH %s exp %0h got %0h", N, E, G); end end
module pps_seq_tb_top;
  import pps_pkg::*;
  logic ref_clk_i = 0;
  logic rst_i = 1;
  logic shutdown_request_low = 1;
  pps_apb_req_type apb = '0;
  pps_strap_type strap = 6'h15;
  logic [15:0] sig = 16'h0b9a;
  logic [2:0] cls = 3'h1;
  logic pm_over = 0;
  logic over = 0;
  pps_meas_type meas;
  logic [31:0] prdata;
  logic pready, pslverr, class_probe, port_on, led_o, led_oe;
  logic [1:0] det_force, pm_source, icut;
  wire logic led_i;
  int compares = 0;
  int failures = 0;
  bit seen_cls, seen_pm, seen_on;
  bit clr_seen = 0;
  // clock and pulled-up led wire
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  assign led_i = led_oe ? led_o : 1'b1;
  pps_seq #(.TICK_CYCLES(4)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .apb_i(apb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .strap_i(strap),
    .shutdown_request_low_i(shutdown_request_low), .meas_i(meas),
    .det_force_o(det_force), .class_probe_o(class_probe),
    .pm_source_o(pm_source), .port_on_o(port_on), .icut_level_o(icut),
    .led_i(led_i), .led_o(led_o), .led_oe_o(led_oe));
  pps_pd_model pd (.ref_clk_i(ref_clk_i), .det_force_i(det_force),
    .class_probe_i(class_probe), .sig_mv_i(sig), .cls_i(cls),
    .pm_over_i(pm_over), .over_i(over), .meas_o(meas));
  // phase order seen on the way to power
  always @(posedge ref_clk_i) begin
    if (class_probe === 1'b1) seen_cls <= 1;
    if (seen_cls && pm_source !== PM_NONE) seen_pm <= 1;
    if (clr_seen) seen_on <= 0;
    else if (port_on === 1'b1) seen_on <= 1;
  end
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // one apb transfer, held until pready at a rising edge
  task automatic apb_xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    apb <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk_i);
    apb.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    apb <= '0;
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    @(posedge ref_clk_i);
  endtask : apb_xfer
  // bounded wait on port power (0) or test current (1)
  task automatic wait_for(input int which, input logic [1:0] v,
      input int lim, input bit must, output bit ok);
    ok = 0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge ref_clk_i);
      ok = ((which == 0 ? {1'b0, port_on} : det_force) === v);
    end
    @(posedge ref_clk_i);
    if (must && !ok) begin
      failures++;
      finish_test();
    end
  endtask : wait_for
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    bit ok;
    int n;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 0;
    @(posedge ref_clk_i);
    apb_xfer(0, ADDR_STATUS, 0, q, e);
    `CHK("on_rst", 1'b0, q[8])
    `CHK("led_rst", 1'b1, q[9])
    apb_xfer(0, 8'h0c, 0, q, e);
    `CHK("slverr", 1'b1, e)
    apb_xfer(1, ADDR_CTRL, 0, q, e);
    `CHK("ctrl_err", 1'b0, e)
    // top of valid range, class 1 under enforcement
    wait_for(0, 1, 3000, 1, ok);
    `CHK("order", 1'b1, seen_pm)
    `CHK("icut", ICUT_100, icut)
    `CHK("pm_src", PM_C1, pm_source)
    `CHK("led_on", 1'b1, led_oe)
    // single supply pulses the lit led
    strap.logic_supply_high <= 0;
    repeat (10) @(posedge ref_clk_i);
    n = 0;
    repeat (100) begin
      @(negedge ref_clk_i);
      n += (led_oe === 1'b1);
    end
    @(posedge ref_clk_i);
    `CHK("pwm", 6, n)
    strap.logic_supply_high <= 1;
    // shutdown while powered, then release delay
    shutdown_request_low <= 0;
    wait_for(0, 0, 10, 1, ok);
    `CHK("led_sd", 1'b0, led_oe)
    wait_for(1, DET_I1, 2000, 0, ok);
    `CHK("det_sd", 1'b0, ok)
    shutdown_request_low <= 1;
    wait_for(1, DET_I1, 15800, 0, ok);
    `CHK("sd_wait", 1'b0, ok)
    wait_for(1, DET_I1, 400, 1, ok);
    // overload removes power after its window
    wait_for(0, 1, 3000, 1, ok);
    over <= 1;
    wait_for(0, 0, 230, 0, ok);
    `CHK("ovl_early", 1'b0, ok)
    wait_for(0, 0, 60, 1, ok);
    over <= 0;
    sig <= 16'h0bb8;
    apb_xfer(0, ADDR_STATUS, 0, q, e);
    `CHK("flt_ovl", FLT_OVLD, q[7:6])
    // slope just past the valid range
    wait_for(1, DET_I2, 17000, 1, ok);
    wait_for(1, DET_OFF, 700, 1, ok);
    apb_xfer(0, ADDR_STATUS, 0, q, e);
    `CHK("flt_sig", FLT_SIG, q[7:6])
    `CHK("sig_off", 1'b0, q[8])
    apb_xfer(0, ADDR_SIG, 0, q, e);
    `CHK("sig_slope", 16'h0bb8, q[15:0])
    // budget node over: attempt ends without power
    sig <= 16'h09c4;
    pm_over <= 1;
    wait_for(1, DET_I1, 3000, 1, ok);
    clr_seen <= 1;
    @(posedge ref_clk_i);
    clr_seen <= 0;
    wait_for(1, DET_OFF, 1200, 1, ok);
    wait_for(1, DET_I1, 3000, 1, ok);
    `CHK("pm_refuse", 1'b0, seen_on)
    `CHK("pm_drop", PM_NONE, pm_source)
    apb_xfer(0, ADDR_STATUS, 0, q, e);
    `CHK("flt_pm", FLT_PM, q[7:6])
    // class 5 handled as class 3
    pm_over <= 0;
    cls <= 3'h5;
    wait_for(0, 1, 3000, 1, ok);
    `CHK("pm_c5", PM_FULL, pm_source)
    `CHK("icut_c5", ICUT_375, icut)
    finish_test();
  end
endmodule : pps_seq_tb_top
`default_nettype wire

// ---- verilog/pps_pkg.sv ----
// constants, codes and carrier types of the port sequencer
// assumes a 100 MHz reference clock and a 1 ms sequencer tick
package pps_pkg;
  // timebase
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TICK_MS = 1;
  // intervals in ms and in ticks
  localparam int DET_SETTLE_MS = 140;
  localparam int DET_PERIOD_MS = 580;
  localparam int BACKOFF_MS = 3200;
  localparam int SD_DELAY_MS = 4000;
  localparam int ERR_DELAY_MS = 4000;
  localparam int CLASS_MS = 37;
  localparam int PM_SETTLE_MS = 10;
  localparam int OVLD_MS = 62;
  localparam int DISC_MS = 350;
  localparam int BLINK_MS = 250;
  localparam int SLOT_MS = 500;
  typedef logic [12:0] pps_tk_type;
  localparam pps_tk_type DET_SETTLE_TK = pps_tk_type'(DET_SETTLE_MS / TICK_MS);
  localparam pps_tk_type DET_PERIOD_TK = pps_tk_type'(DET_PERIOD_MS / TICK_MS);
  localparam pps_tk_type BACKOFF_TK = pps_tk_type'(BACKOFF_MS / TICK_MS);
  localparam pps_tk_type SD_DELAY_TK = pps_tk_type'(SD_DELAY_MS / TICK_MS);
  localparam pps_tk_type ERR_DELAY_TK = pps_tk_type'(ERR_DELAY_MS / TICK_MS);
  localparam pps_tk_type CLASS_TK = pps_tk_type'(CLASS_MS / TICK_MS);
  localparam pps_tk_type PM_SETTLE_TK = pps_tk_type'(PM_SETTLE_MS / TICK_MS);
  localparam pps_tk_type OVLD_TK = pps_tk_type'(OVLD_MS / TICK_MS);
  localparam pps_tk_type DISC_TK = pps_tk_type'(DISC_MS / TICK_MS);
  localparam pps_tk_type BLINK_TK = pps_tk_type'(BLINK_MS / TICK_MS);
  localparam pps_tk_type SLOT_TK = pps_tk_type'(SLOT_MS / TICK_MS);
  // detection thresholds in mV; test currents differ by 100 uA
  localparam logic [15:0] SIG_MIN_MV = 16'h06a4;
  localparam logic [15:0] SIG_MAX_MV = 16'h0b9a;
  localparam logic [15:0] SHORT_MV = 16'h0064;
  localparam logic [15:0] OPEN_MV = 16'h2af8;
  localparam logic [15:0] FORCE_MIN_MV = 16'h03e8;
  localparam logic [15:0] FORCE_MAX_MV = 16'h2710;
  // led pulse drive, 6 of every 100 cycles
  localparam logic [6:0] PWM_PERIOD = 7'h64;
  localparam logic [6:0] PWM_ON = 7'h06;
  // codes
  localparam logic [1:0] FLT_NONE = 2'h0;
  localparam logic [1:0] FLT_OVLD = 2'h1;
  localparam logic [1:0] FLT_SIG = 2'h2;
  localparam logic [1:0] FLT_PM = 2'h3;
  localparam logic [1:0] DET_OFF = 2'h0;
  localparam logic [1:0] DET_I1 = 2'h1;
  localparam logic [1:0] DET_I2 = 2'h2;
  localparam logic [1:0] ICUT_375 = 2'h0;
  localparam logic [1:0] ICUT_100 = 2'h1;
  localparam logic [1:0] ICUT_175 = 2'h2;
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_C1 = 2'h1;
  localparam logic [1:0] PM_C2 = 2'h2;
  localparam logic [1:0] PM_FULL = 2'h3;
  localparam logic [1:0] LEG_STD = 2'h0;
  localparam logic [1:0] LEG_CAP = 2'h1;
  localparam logic [1:0] LEG_FORCE = 2'h2;
  // register map and fields
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SIG = 8'h08;
  localparam int CTRL_DIS_BIT = 0;
  localparam logic [6:0] SYNC_RST = 7'h40;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_DET1 = 4'h1, ST_DET2 = 4'h2, ST_BACKOFF = 4'h3,
    ST_CLASS = 4'h4, ST_PM_CHECK = 4'h5, ST_PM_VERIFY = 4'h6, ST_ON = 4'h7,
    ST_ERR_WAIT = 4'h8, ST_SHUT = 4'h9, ST_SD_WAIT = 4'ha
  } pps_state_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pps_apb_req_type;
  typedef struct packed {
    logic legacy_high;
    logic legacy_low;
    logic midspan;
    logic class_limit_enforce;
    logic ac_sense_oscillator;
    logic logic_supply_high;
  } pps_strap_type;
  typedef struct packed {
    logic [15:0] volt_mv;
    logic cap_big;
    logic [2:0] class_code;
    logic pm_over;
    logic over_cut;
    logic ac_cap_low;
    logic dc_mps_absent;
  } pps_meas_type;
endpackage : pps_pkg

// ---- verilog/pps_seq.sv ----
// port sequencer: detection, class, power budget, power, disconnect, led
// assumes analog results synchronous to ref_clk_i; straps are asynchronous
//
// Notes on behaviour
// [RULE1] led pulled low while port powered, released otherwise
// [RULE2] a port fault flashes the led with a count per fault kind
// [RULE3] on single 48V supply lit led is pulsed low at 6% duty
// [RULE4] legacy strap high: large port capacitance accepted as legacy device
// [RULE5] legacy strap low: only standard signatures accepted
// [RULE6] legacy floating: power any device reading 1V to 10V
// [RULE7] midspan high: 3.2 s wait after failed detection unless open
// [RULE8] midspan low: no extra wait after failed detection
// [RULE9] source class-proportional budget current while powering
// [RULE10] refuse turn-on when budget node is above 1V before power
// [RULE11] oscillator strap low selects dc disconnect instead of ac
// [RULE12] ac mode: low port capacitance past window turns port off
// [RULE13] shutdown low: no detection, no power, port turned off
// [RULE14] after shutdown release wait 4 s before detecting
// [RULE15] enforce strap lowers overload threshold for class 1 and 2
// [RULE16] two test currents, settle, measure, difference gives slope
// [RULE17] slope between 17k and 29.7k is a valid device
// [RULE18] out-of-range signature, not open or short, gets its flash code
// [RULE19] over 5 uF withholds power unless legacy mode enabled
// [RULE20] detection repeats every 580 ms, or 3.2 s with backoff
// [RULE21] detection, then class, then budget check, then power
// [RULE22] budget over after adding current: withdraw, abort, redetect
// [RULE23] class 4 and above handled as class 3
// [RULE24] overload for longer than 62 ms removes port power
// [RULE25] all intervals counted in ticks of one timebase; the led pulse drive counts ref_clk_i cycles instead
// [RULE26] straps and shutdown synchronised; floating legacy is its own state
`timescale 1ns/1ps
`default_nettype none

module pps_seq #(
  parameter int TICK_CYCLES = pps_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire pps_pkg::pps_apb_req_type apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // straps and shutdown
  input wire pps_pkg::pps_strap_type strap_i,
  input wire logic shutdown_request_low_i,
  // analog front end results
  input wire pps_pkg::pps_meas_type meas_i,
  // analog front end controls
  output logic [1:0] det_force_o,
  output logic class_probe_o,
  output logic [1:0] pm_source_o,
  output logic port_on_o,
  output logic [1:0] icut_level_o,
  // open-drain led
  input wire logic led_i,
  output logic led_o,
  output logic led_oe_o
);
  import pps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // strap synchronisers
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  pps_strap_type st_s;
  logic sd_n_s;
  logic [1:0] leg_mode;
  logic single;
  logic ac_mode;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
    end else begin
      sync_a <= {shutdown_request_low_i, strap_i}; // RULE26
      sync_b <= sync_a;
    end
  end

  // strap decode, floating legacy as third state
  assign st_s = pps_strap_type'(sync_b[5:0]);
  assign sd_n_s = sync_b[6];
  assign leg_mode = st_s.legacy_high ? LEG_CAP :
                    (st_s.legacy_low ? LEG_STD : LEG_FORCE); // RULE26
  assign single = !st_s.logic_supply_high;
  assign ac_mode = st_s.ac_sense_oscillator; // RULE11

  ////////////////////////////////////////////////////////////////////////////
  // timebase
  logic [16:0] tick_cnt;
  logic tick;
  assign tick = (tick_cnt == 17'(TICK_CYCLES - 1)); // RULE25

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || tick) tick_cnt <= 17'h0;
    else tick_cnt <= tick_cnt + 17'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state, timers and latched results
  pps_state_type state;
  pps_state_type next_state;
  logic [1:0] fault;
  logic [1:0] next_fault;
  logic ctrl_dis;
  logic sd_active;
  pps_tk_type st_tk;
  pps_tk_type cyc_tk;
  pps_tk_type ovl_tk;
  pps_tk_type disc_tk;
  logic [15:0] v1_mv;
  logic [15:0] sig_mv;
  logic fail_open;
  logic [1:0] class_lvl;

  assign sd_active = !sd_n_s || ctrl_dis; // RULE13

  // signature evaluation at the second point
  logic [15:0] v2_mv;
  logic [15:0] dv_mv;
  logic sig_neg;
  logic is_open;
  logic is_short;
  logic in_rng;
  logic force_ok;
  logic sig_ok;
  logic sig_bad;
  logic absent;
  logic st_done_det;
  pps_tk_type backoff_lim;

  assign v2_mv = meas_i.volt_mv;
  assign dv_mv = v2_mv - v1_mv; // RULE16
  assign sig_neg = v2_mv < v1_mv;
  assign is_open = v2_mv >= OPEN_MV;
  assign is_short = sig_neg || (dv_mv < SHORT_MV);
  assign in_rng = !sig_neg && dv_mv >= SIG_MIN_MV && dv_mv <= SIG_MAX_MV; // RULE17
  assign force_ok = v2_mv >= FORCE_MIN_MV && v2_mv <= FORCE_MAX_MV; // RULE6
  assign sig_ok = (leg_mode == LEG_FORCE) ? force_ok :
                  ((leg_mode == LEG_CAP && meas_i.cap_big) ? 1'b1 : // RULE4
                   (in_rng && !meas_i.cap_big)); // RULE5 RULE19
  assign sig_bad = !is_open && !is_short && !in_rng; // RULE18
  assign st_done_det = st_tk >= DET_SETTLE_TK;
  assign backoff_lim = (st_s.midspan && !fail_open) ? BACKOFF_TK
                                                    : DET_PERIOD_TK; // RULE7 RULE8 RULE20
  assign absent = ac_mode ? meas_i.ac_cap_low : meas_i.dc_mps_absent; // RULE11

  // sequencer transitions
  always_comb begin
    next_state = state;
    next_fault = fault;
    if (sd_active) begin
      next_state = ST_SHUT; // RULE13
    end else begin
      case (state)
        ST_SHUT: next_state = ST_SD_WAIT;
        ST_SD_WAIT: if (st_tk >= SD_DELAY_TK) next_state = ST_IDLE; // RULE14
        ST_IDLE: next_state = ST_DET1;
        ST_DET1: if (st_done_det) next_state = ST_DET2; // RULE16
        ST_DET2: begin
          if (st_done_det) begin
            next_state = sig_ok ? ST_CLASS : ST_BACKOFF; // RULE21
            if (!sig_ok && sig_bad) next_fault = FLT_SIG; // RULE18
          end
        end
        ST_BACKOFF: if (cyc_tk >= backoff_lim) next_state = ST_DET1; // RULE20
        ST_CLASS: if (st_tk >= CLASS_TK) next_state = ST_PM_CHECK; // RULE21
        ST_PM_CHECK: begin
          if (meas_i.pm_over) begin
            next_state = ST_IDLE; // RULE10
            next_fault = FLT_PM;
          end else begin
            next_state = ST_PM_VERIFY;
          end
        end
        ST_PM_VERIFY: begin
          if (st_tk >= PM_SETTLE_TK) begin
            if (meas_i.pm_over) begin
              next_state = ST_IDLE; // RULE22
              next_fault = FLT_PM;
            end else begin
              next_state = ST_ON; // RULE21
              next_fault = FLT_NONE;
            end
          end
        end
        ST_ON: begin
          if (ovl_tk > OVLD_TK) begin
            next_state = ST_ERR_WAIT; // RULE24
            next_fault = FLT_OVLD;
          end else if (disc_tk > DISC_TK) begin
            next_state = ST_IDLE; // RULE12
          end
        end
        ST_ERR_WAIT: if (st_tk >= ERR_DELAY_TK) next_state = ST_IDLE;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      fault <= FLT_NONE;
    end else begin
      state <= next_state;
      fault <= next_fault;
    end
  end

  // tick timers: per state, per detection cycle, overload, disconnect
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || next_state != state) st_tk <= '0;
    else if (tick) st_tk <= st_tk + 13'h1; // RULE25
    if (rst_i || (next_state == ST_DET1 && state != ST_DET1)) cyc_tk <= '0;
    else if (tick) cyc_tk <= cyc_tk + 13'h1;
    if (rst_i || state != ST_ON || !meas_i.over_cut) ovl_tk <= '0;
    else if (tick) ovl_tk <= ovl_tk + 13'h1; // RULE24
    if (rst_i || state != ST_ON || !absent) disc_tk <= '0;
    else if (tick) disc_tk <= disc_tk + 13'h1; // RULE12
  end

  // first point store, slope and class capture
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      v1_mv <= 16'h0;
      sig_mv <= 16'h0;
      fail_open <= 1'b0;
      class_lvl <= 2'h0;
    end else begin
      if (state == ST_DET1 && next_state == ST_DET2) v1_mv <= v2_mv; // RULE16
      if (state == ST_DET2 && next_state != ST_DET2) begin
        sig_mv <= dv_mv;
        fail_open <= is_open;
      end
      if (state == ST_CLASS && next_state == ST_PM_CHECK) begin
        class_lvl <= meas_i.class_code[2] ? 2'h3
                                          : meas_i.class_code[1:0]; // RULE23
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // front end drive
  logic [1:0] pm_lvl;
  logic [1:0] next_icut;
  logic [1:0] next_det;
  logic [1:0] next_pm;
  logic next_on;

  assign pm_lvl = (class_lvl == 2'h1) ? PM_C1 :
                  ((class_lvl == 2'h2) ? PM_C2 : PM_FULL);
  assign next_icut = !st_s.class_limit_enforce ? ICUT_375 : // RULE15
                     ((class_lvl == 2'h1) ? ICUT_100 :
                      ((class_lvl == 2'h2) ? ICUT_175 : ICUT_375));
  assign next_det = (next_state == ST_DET1) ? DET_I1 :
                    ((next_state == ST_DET2) ? DET_I2 : DET_OFF);
  assign next_pm = (next_state == ST_PM_VERIFY || next_state == ST_ON)
                   ? pm_lvl : PM_NONE; // RULE9 RULE22
  assign next_on = next_state == ST_ON;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      det_force_o <= DET_OFF;
      class_probe_o <= 1'b0;
      pm_source_o <= PM_NONE;
      port_on_o <= 1'b0;
      icut_level_o <= ICUT_375;
    end else begin
      det_force_o <= next_det;
      class_probe_o <= next_state == ST_CLASS;
      pm_source_o <= next_pm; // RULE9
      port_on_o <= next_on;
      icut_level_o <= next_icut;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // led: on while powered, fault flash counts, pulse drive
  logic [6:0] pwm_cnt;
  pps_tk_type slot_tk;
  logic [1:0] slot;
  logic led_want;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || pwm_cnt == PWM_PERIOD - 7'h1) pwm_cnt <= 7'h0;
    else pwm_cnt <= pwm_cnt + 7'h1;
    if (rst_i) begin
      slot_tk <= '0;
      slot <= 2'h0;
    end else if (tick) begin
      if (slot_tk == SLOT_TK - 13'h1) begin
        slot_tk <= '0;
        slot <= slot + 2'h1;
      end else begin
        slot_tk <= slot_tk + 13'h1;
      end
    end
  end

  assign led_want = next_on || // RULE1
                    (slot < fault && slot_tk < BLINK_TK); // RULE2

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) led_oe_o <= 1'b0;
    else led_oe_o <= led_want && (!single || pwm_cnt < PWM_ON); // RULE3
  end
  assign led_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  logic sel_ctrl;
  logic sel_status;
  logic sel_sig;
  logic mapped;
  logic acc;
  logic [31:0] rd_mux;

  assign sel_ctrl = apb_i.paddr == ADDR_CTRL;
  assign sel_status = apb_i.paddr == ADDR_STATUS;
  assign sel_sig = apb_i.paddr == ADDR_SIG;
  assign mapped = sel_ctrl || sel_status || sel_sig;
  assign acc = apb_i.psel && apb_i.penable;
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign rd_mux = sel_ctrl ? {31'h0, ctrl_dis} :
                  sel_status ? {18'h0, ac_mode, st_s.midspan, leg_mode, led_i,
                                port_on_o, fault, class_lvl, state} :
                  sel_sig ? {16'h0, sig_mv} : 32'h0;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_dis <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      if (acc && apb_i.pwrite && sel_ctrl) ctrl_dis <= apb_i.pwdata[CTRL_DIS_BIT];
      prdata_o <= (apb_i.psel && !apb_i.penable) ? rd_mux : prdata_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_LED_ON: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE1
    port_on_o && !$past(single) |-> led_oe_o) else $error("led not lit while on");
  AST_LED_DUTY: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
    led_oe_o && $past(single) |-> $past(pwm_cnt) < PWM_ON)
    else $error("led pulse beyond duty");
  AST_SD_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE13
    sd_active |=> !port_on_o && det_force_o == DET_OFF)
    else $error("port active under shutdown");
  AST_SD_WAIT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE14
    state == ST_SD_WAIT && st_tk < SD_DELAY_TK |=> det_force_o == DET_OFF)
    else $error("detection before release delay");
  AST_PM_REFUSE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE10
    state == ST_PM_CHECK && meas_i.pm_over && !sd_active
    |=> state == ST_IDLE ##1 !port_on_o) else $error("budget check ignored");
  AST_PM_WITHDRAW: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE22
    state == ST_PM_VERIFY && st_tk >= PM_SETTLE_TK && meas_i.pm_over
    |=> pm_source_o == PM_NONE && !port_on_o)
    else $error("budget current not withdrawn");
  AST_ICUT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE15
    !st_s.class_limit_enforce |=> icut_level_o == ICUT_375)
    else $error("threshold lowered without enforce");
  AST_ORDER: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE21
    $rose(port_on_o) |-> $past(state) == ST_PM_VERIFY)
    else $error("power without budget check");
  AST_OVLD: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE24
    state == ST_ON && ovl_tk > OVLD_TK && !sd_active
    |=> !port_on_o && fault == FLT_OVLD)
    else $error("overload not removed");
  AST_CLASS4: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE23
    state == ST_CLASS && st_tk >= CLASS_TK && meas_i.class_code[2] && !sd_active
    |=> class_lvl == 2'h3) else $error("class 4 not folded to 3");
  AST_DISC: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE12
    state == ST_ON && disc_tk > DISC_TK |=> !port_on_o)
    else $error("disconnect not acted on");
  COV_POWER: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(port_on_o));
  COV_OVLD: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    state == ST_ON ##1 state == ST_ERR_WAIT);
  COV_BACKOFF: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    state == ST_BACKOFF && backoff_lim == BACKOFF_TK);
endmodule : pps_seq

`default_nettype wire
